// *** esp_uart.sv ***
// Serial port core: shift mode and three asynchronous modes.
// Assumes timer overflow pulses come from timers outside this block and
// all inputs are synchronous to clk.
//
// What this block does
// R01 - Four modes from two select bits
// R02 - Transmit starts after next divide-by-16 rollover
// R03 - Ten-bit frame; done flag at stop
// R04 - Receive only when enabled, on falling edge
// R05 - Sample 16x; reset counter at start edge
// R06 - Majority vote of samples seven, eight, nine
// R07 - Bad start bit aborts and rearms receiver
// R08 - Ten-bit load gated by flag and stop
// R09 - Rearm after frame; software clears done flag
// R10 - Eleven-bit frame with programmable ninth bit
// R11 - Buffer write copies ninth bit into shifter
// R12 - Eleven-bit done flag at eleventh rollover
// R13 - Eleven-bit load gated by ninth bit, address
// R14 - Eleven-bit stop bit is not stored
// R15 - Mode three: nine-bit frame, timer rate
// R16 - Mode two: clock over 64 or 32
// R17 - Shift mode: clock over 12 or 4
// R18 - Timer1 overflow rate, doubler selects halving
// R19 - Timer2 system clock: overflow over 32
// R20 - Timer2 external clock: overflow over 16
// R21 - Shared baud source selects Timer1 or Timer2
`timescale 1ns/1ps
module esp_uart (
   input wire logic clk,
   input wire logic nrst,
   input wire logic mode_select_high,
   input wire logic mode_select_low,
   input wire logic multiproc_select_bit,
   input wire logic baud_doubler,
   input wire logic rx_enable,
   input wire logic baud_src_timer2,
   input wire logic timer2_ext_clk,
   input wire logic timer1_ovf,
   input wire logic timer2_ovf,
   input wire logic serial_buffer_wr,
   input wire logic [7:0] serial_buffer_wdata,
   input wire logic tx_ninth_bit,
   input wire logic tx_done_clr,
   input wire logic rx_done_clr,
   input wire logic [7:0] slave_addr,
   input wire logic [7:0] slave_mask,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe_n,
   output logic txd,
   output logic tx_done_flag,
   output logic rx_done_flag,
   output logic rx_ninth_bit,
   output logic rx_valid,
   input wire logic rx_ready,
   output esp_pkg::esp_rx_word_t rx_word
);
   typedef enum logic [2:0] {
      TX_IDLE, TX_WAIT, TX_SEND, SH_TX, SH_RX
   } esp_tx_state_t;
   typedef enum logic {RX_IDLE, RX_BITS} esp_rx_state_t;

   // Reset release through two flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Mode decode
   wire [1:0] mode = {mode_select_high, mode_select_low};
   wire is_shift = mode == esp_pkg::MODE_SHIFT; // R01
   wire is_fixed = mode == esp_pkg::MODE_FIX9; // R16
   wire is_nine = mode_select_high; // R10 R15
   wire [3:0] last_bit = is_nine ? esp_pkg::LAST_BIT_11
                                 : esp_pkg::LAST_BIT_10;

   // Baud tick at 16x bit rate
   logic [1:0] pre;
   wire src_evt = is_fixed ? 1'b1
                : baud_src_timer2 ? timer2_ovf : timer1_ovf; // R21
   wire [1:0] t1_last = baud_doubler ? esp_pkg::PRE_T1_FAST
                                     : esp_pkg::PRE_T1_SLOW; // R18
   wire [1:0] t2_last = timer2_ext_clk ? esp_pkg::PRE_T2_EXT
                                       : esp_pkg::PRE_T2_SYS; // R19 R20
   wire [1:0] m2_last = baud_doubler ? esp_pkg::PRE_M2_FAST
                                     : esp_pkg::PRE_M2_SLOW; // R16
   wire [1:0] pre_last = is_fixed ? m2_last
                       : baud_src_timer2 ? t2_last : t1_last;
   wire os_tick = src_evt && pre == pre_last;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pre <= 2'h0;
      else if (os_tick) pre <= 2'h0;
      else if (src_evt) pre <= pre + 2'h1;
   end

   // Free-running divide-by-16 for the transmitter
   logic [3:0] tx_div;
   wire tx_roll = os_tick && tx_div == esp_pkg::OS_LAST;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tx_div <= 4'h0;
      else if (os_tick) tx_div <= tx_div + 4'h1;
   end

   // Shift mode clock
   wire [3:0] m0_last = multiproc_select_bit ? esp_pkg::M0_FAST_LAST
                                             : esp_pkg::M0_SLOW_LAST; // R17
   wire [3:0] m0_mid = multiproc_select_bit ? esp_pkg::M0_FAST_MID
                                            : esp_pkg::M0_SLOW_MID;

   // Transmit path; shift mode shares the shifter
   esp_tx_state_t tx_state;
   logic [10:0] tx_sh;
   logic [3:0] tx_bits;
   logic [3:0] m0_cnt;
   wire tx_free = tx_state == TX_IDLE;
   // Writes while busy are dropped; the frame in flight is kept
   wire tx_start = serial_buffer_wr && tx_free;
   wire m0_fall = m0_cnt == m0_last;
   wire m0_rise = m0_cnt == m0_mid;
   wire m0_rx_start = is_shift && tx_free && !serial_buffer_wr
                    && rx_enable && !rx_done_flag;
   wire m0_tx_end = tx_state == SH_TX && m0_fall
                  && tx_bits == esp_pkg::M0_BITS;
   wire m0_load = tx_state == SH_RX && m0_rise
                && tx_bits == esp_pkg::M0_BITS - 4'h1;
   wire tx_stop = tx_state == TX_SEND && tx_roll && tx_bits == last_bit;
   wire tx_sh_bit9 = is_nine ? tx_ninth_bit : 1'b1; // R11

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state <= TX_IDLE;
         tx_sh <= 11'h7FF;
         tx_bits <= 4'h0;
         m0_cnt <= 4'h0;
         txd <= 1'b1;
         rxd_out <= 1'b1;
         rxd_oe_n <= 1'b1;
      end else begin
         m0_cnt <= m0_fall ? 4'h0 : m0_cnt + 4'h1;
         case (tx_state)
            TX_IDLE: begin
               tx_bits <= 4'h0;
               m0_cnt <= 4'h0;
               if (tx_start && is_shift) begin
                  tx_sh <= {3'h7, serial_buffer_wdata};
                  rxd_oe_n <= 1'b0;
                  tx_state <= SH_TX;
               end else if (tx_start) begin
                  tx_sh <= {1'b1, tx_sh_bit9, serial_buffer_wdata,
                            1'b0}; // R10 R11
                  tx_state <= TX_WAIT;
               end else if (m0_rx_start) begin
                  tx_state <= SH_RX;
               end
            end
            TX_WAIT: begin
               if (tx_roll) begin // R02
                  txd <= tx_sh[0];
                  tx_sh <= {1'b1, tx_sh[10:1]};
                  tx_bits <= 4'h1;
                  tx_state <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (tx_roll && tx_bits > last_bit) begin
                  tx_state <= TX_IDLE;
               end else if (tx_roll) begin // R03 R10
                  txd <= tx_sh[0];
                  tx_sh <= {1'b1, tx_sh[10:1]};
                  tx_bits <= tx_bits + 4'h1;
               end
            end
            SH_TX: begin
               // Data changes on the falling edge of the shift clock
               if (m0_tx_end) begin
                  txd <= 1'b1;
                  rxd_out <= 1'b1;
                  rxd_oe_n <= 1'b1;
                  tx_state <= TX_IDLE;
               end else if (m0_fall) begin
                  txd <= 1'b0;
                  rxd_out <= tx_sh[0];
                  tx_sh <= {1'b0, tx_sh[10:1]};
                  tx_bits <= tx_bits + 4'h1;
               end else if (m0_rise) begin
                  txd <= 1'b1;
               end
            end
            SH_RX: begin
               // Data latched on the rising edge of the shift clock
               if (m0_fall) begin
                  txd <= 1'b0;
               end else if (m0_rise) begin
                  txd <= 1'b1;
                  tx_sh <= {3'h7, rxd_in, tx_sh[7:1]};
                  tx_bits <= tx_bits + 4'h1;
                  if (m0_load) tx_state <= TX_IDLE;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Transmit done flag: a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tx_done_flag <= 1'b0;
      else if (tx_stop || m0_tx_end) tx_done_flag <= 1'b1; // R03 R12
      else if (tx_done_clr) tx_done_flag <= 1'b0;
   end

   // Asynchronous receiver
   esp_rx_state_t rx_state;
   logic rx_prev;
   logic [3:0] rx_div;
   logic [3:0] rx_bits;
   logic rx_s7;
   logic rx_s8;
   logic [8:0] rx_sh;
   wire rx_fall = os_tick && rx_state == RX_IDLE && !is_shift
                && rx_enable && rx_prev && !rxd_in; // R04
   wire rx_vote_pt = os_tick && rx_state == RX_BITS
                   && rx_div == esp_pkg::VOTE_S9;
   wire vote = (rx_s7 & rx_s8) | (rx_s7 & rxd_in) | (rx_s8 & rxd_in); // R06
   wire rx_abort = rx_vote_pt && rx_bits == 4'h0 && vote; // R07
   wire rx_finish = rx_vote_pt && rx_bits == last_bit;
   wire [7:0] rx_byte = is_nine ? rx_sh[7:0] : rx_sh[8:1];
   wire rx_nb = is_nine ? rx_sh[8] : vote; // R08 R14
   wire given_ok = ((rx_byte ^ slave_addr) & slave_mask) == 8'h00;
   wire [7:0] bcast = slave_addr | slave_mask;
   wire bcast_ok = (rx_byte & bcast) == bcast;
   wire addr_ok = given_ok || bcast_ok;
   wire buf_ready;
   wire mp_ok = !multiproc_select_bit
              || (is_nine ? rx_sh[8] && addr_ok : vote); // R08 R13
   // A full buffer drops the frame like a set done flag
   wire async_load = rx_finish && !rx_done_flag && buf_ready && mp_ok;
   wire load = async_load || m0_load;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state <= RX_IDLE;
         rx_prev <= 1'b1;
         rx_div <= 4'h0;
         rx_bits <= 4'h0;
         rx_s7 <= 1'b1;
         rx_s8 <= 1'b1;
         rx_sh <= 9'h000;
      end else if (rx_state == RX_IDLE) begin
         if (os_tick) rx_prev <= rxd_in;
         if (rx_fall) begin
            rx_div <= 4'h0; // R05
            rx_bits <= 4'h0;
            rx_state <= RX_BITS;
         end
      end else if (os_tick) begin
         rx_div <= rx_div + 4'h1; // R05
         if (rx_div == esp_pkg::VOTE_S7) rx_s7 <= rxd_in; // R06
         if (rx_div == esp_pkg::VOTE_S8) rx_s8 <= rxd_in; // R06
         if (rx_abort || rx_finish) begin // R07 R09
            rx_state <= RX_IDLE;
            rx_prev <= rxd_in;
         end else if (rx_vote_pt) begin
            if (rx_bits != 4'h0) rx_sh <= {vote, rx_sh[8:1]};
            rx_bits <= rx_bits + 4'h1;
         end
      end
   end

   // Receive flags; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_done_flag <= 1'b0;
         rx_ninth_bit <= 1'b0;
      end else begin
         if (load) rx_done_flag <= 1'b1; // R08 R13
         else if (rx_done_clr) rx_done_flag <= 1'b0; // R09
         if (async_load) rx_ninth_bit <= rx_nb; // R08 R13
      end
   end

   esp_pkg::esp_rx_word_t in_word;
   assign in_word.ninth = async_load ? rx_nb : rx_ninth_bit;
   // Shift receive takes its eighth bit in the load cycle itself
   assign in_word.data = async_load ? rx_byte : {rxd_in, tx_sh[7:1]};

   esp_buf2 #(.W($bits(esp_pkg::esp_rx_word_t))) u_rx_buf (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(load),
      .in_ready(buf_ready),
      .in_data(in_word),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_word)
   );

   // Checks
   wire m2_slow = is_fixed && !baud_doubler;
   sequence s_m2_tick;
      m2_slow && os_tick ##1 m2_slow [*3];
   endsequence
   sequence s_async_write;
      tx_start && !is_shift;
   endsequence

   property p_tx_roll_start;
      @(posedge clk) disable iff (!rst_n)
      tx_state == TX_WAIT && tx_roll |=> !txd && tx_state == TX_SEND;
   endproperty
   a_tx_roll_start: assert property (p_tx_roll_start) // R02
      else $error("start bit not driven after rollover");

   property p_tx_stop_flag;
      @(posedge clk) disable iff (!rst_n)
      tx_stop |=> tx_done_flag && txd;
   endproperty
   a_tx_stop_flag: assert property (p_tx_stop_flag) // R12
      else $error("done flag not set at stop bit");

   property p_rx_disabled;
      @(posedge clk) disable iff (!rst_n)
      rx_state == RX_IDLE && !rx_enable |=> rx_state == RX_IDLE;
   endproperty
   a_rx_disabled: assert property (p_rx_disabled) // R04
      else $error("receiver started while disabled");

   property p_rx_align;
      @(posedge clk) disable iff (!rst_n)
      rx_fall |=> rx_state == RX_BITS && rx_div == 4'h0;
   endproperty
   a_rx_align: assert property (p_rx_align) // R05
      else $error("counter not reset on start edge");

   property p_rx_abort;
      @(posedge clk) disable iff (!rst_n)
      rx_abort |=> rx_state == RX_IDLE && $stable(rx_sh);
   endproperty
   a_rx_abort: assert property (p_rx_abort) // R07
      else $error("bad start bit did not abort");

   property p_rx_load;
      @(posedge clk) disable iff (!rst_n)
      async_load |=> rx_done_flag && rx_ninth_bit == $past(rx_nb);
   endproperty
   a_rx_load: assert property (p_rx_load) // R08
      else $error("load did not update flags");

   property p_rx_no_overwrite;
      @(posedge clk) disable iff (!rst_n)
      rx_done_flag && !rx_done_clr |=> rx_done_flag && $stable(rx_ninth_bit);
   endproperty
   a_rx_no_overwrite: assert property (p_rx_no_overwrite) // R09
      else $error("frame loaded while done flag set");

   property p_tx_ninth;
      @(posedge clk) disable iff (!rst_n)
      s_async_write and is_nine |=> tx_sh[9] == $past(tx_ninth_bit);
   endproperty
   a_tx_ninth: assert property (p_tx_ninth) // R11
      else $error("ninth bit not copied into shifter");

   property p_m2_rate;
      @(posedge clk) disable iff (!rst_n)
      s_m2_tick |-> !os_tick ##1 (os_tick || !m2_slow);
   endproperty
   a_m2_rate: assert property (p_m2_rate) // R16
      else $error("mode two tick spacing wrong");

endmodule : esp_uart

// *** esp_pkg.sv ***
// Constants and types shared by the serial port core and its bench.
// Assumes a single system clock; all counts are in system clocks or
// baud ticks.
package esp_pkg;

   // Mode select encodings {mode_select_high, mode_select_low}
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_VAR8 = 2'h1;
   localparam logic [1:0] MODE_FIX9 = 2'h2;
   localparam logic [1:0] MODE_VAR9 = 2'h3;

   // Oversampling: 16 ticks per bit
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] VOTE_S7 = 4'h7;
   localparam logic [3:0] VOTE_S8 = 4'h8;
   localparam logic [3:0] VOTE_S9 = 4'h9;

   // Prescaler last counts: tick every (last + 1) source events
   localparam logic [1:0] PRE_M2_SLOW = 2'h3;
   localparam logic [1:0] PRE_M2_FAST = 2'h1;
   localparam logic [1:0] PRE_T1_SLOW = 2'h1;
   localparam logic [1:0] PRE_T1_FAST = 2'h0;
   localparam logic [1:0] PRE_T2_SYS = 2'h1;
   localparam logic [1:0] PRE_T2_EXT = 2'h0;

   // Shift mode clock period last count and mid point
   localparam logic [3:0] M0_SLOW_LAST = 4'hB;
   localparam logic [3:0] M0_SLOW_MID = 4'h5;
   localparam logic [3:0] M0_FAST_LAST = 4'h3;
   localparam logic [3:0] M0_FAST_MID = 4'h1;
   localparam logic [3:0] M0_BITS = 4'h8;

   // Last bit index of an asynchronous frame (start = 0)
   localparam logic [3:0] LAST_BIT_10 = 4'h9;
   localparam logic [3:0] LAST_BIT_11 = 4'hA;

   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } esp_rx_word_t;

endpackage : esp_pkg

// *** esp_buf2.sv ***
// Two-entry buffer with valid/ready on both sides; outputs registered.
// Assumes one clock and an active-low asynchronous reset already
// synchronised by the parent.
`timescale 1ns/1ps
module esp_buf2 #(
   parameter int W = 9
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic skid_valid;
   logic [W-1:0] skid_data;
   wire drain = out_ready | ~out_valid;

   assign in_ready = ~skid_valid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_data <= '0;
         skid_valid <= 1'b0;
         skid_data <= '0;
      end else if (drain) begin
         if (skid_valid) begin
            out_data <= skid_data;
            skid_valid <= 1'b0;
         end else begin
            out_valid <= in_valid;
            if (in_valid) out_data <= in_data;
         end
      end else if (in_valid && !skid_valid) begin
         skid_valid <= 1'b1;
         skid_data <= in_data;
      end
   end

   property p_hold_stall;
      @(posedge clk) disable iff (!rst_n)
      out_valid && !out_ready |=> out_valid && $stable(out_data);
   endproperty
   a_hold_stall: assert property (p_hold_stall)
      else $error("buffer head changed while stalled");

endmodule : esp_buf2

// *** esp_node.sv ***
// Far-side serial node: drives the port's receive line, captures txd.
// Assumes the bench clock; line idles high between frames.
`timescale 1ns/1ps
module esp_node (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   initial begin
      line_out = 1'b1;
   end

   // Frame bits LSB first from index 0; bit gb gets a two-clock glitch
   task automatic send(input logic [10:0] bits, input int n, input int per,
         input int gb);
      for (int i = 0; i < n; i++) begin
         for (int c = 0; c < per; c++) begin
            @(posedge clk);
            line_out <= bits[i] ^ (i == gb && (c == 15 || c == 16));
         end
      end
      @(posedge clk);
      line_out <= 1'b1;
   endtask : send

   // Start length measured on the line, then bits taken at mid bit
   task automatic capture(input int n, input int per,
         output logic [10:0] bits, output int low);
      int w;
      bits = '0;
      low = 0;
      w = 0;
      while (line_in !== 1'b0 && w < 5000) begin
         @(posedge clk);
         w++;
      end
      while (line_in === 1'b0 && low < 200) begin
         @(posedge clk);
         low++;
      end
      for (int i = 1; i < n; i++) begin
         repeat ((i == 1) ? per / 2 : per) @(posedge clk);
         bits[i] = line_in;
      end
   endtask : capture
endmodule : esp_node

// *** esp_uart_bench.sv ***
// Self-checking bench for the serial port core.
// Assumes the node model on the serial lines and local timer overflows:
// Timer1 every second clock, Timer2 every clock.
`timescale 1ns/1ps
module esp_uart_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic mode_select_high = 1'b0;
   logic mode_select_low = 1'b0;
   logic multiproc_select_bit = 1'b0;
   logic baud_doubler = 1'b0;
   logic rx_enable = 1'b0;
   logic baud_src_timer2 = 1'b0;
   logic timer2_ext_clk = 1'b0;
   logic timer1_ovf = 1'b0;
   logic timer2_ovf = 1'b0;
   logic ovf_tog = 1'b0;
   logic serial_buffer_wr = 1'b0;
   logic [7:0] serial_buffer_wdata = 8'h00;
   logic tx_ninth_bit = 1'b0;
   logic tx_done_clr = 1'b0;
   logic rx_done_clr = 1'b0;
   logic [7:0] slave_addr = 8'h5A;
   logic [7:0] slave_mask = 8'hFF;
   logic rx_ready = 1'b0;
   logic node_out, rx_line, rxd_out, rxd_oe_n, txd;
   logic tx_done_flag, rx_done_flag, rx_ninth_bit, rx_valid;
   esp_pkg::esp_rx_word_t rx_word;
   int failures = 0;
   int samples_checked = 0;

   initial begin
      forever #50 clk = ~clk;
   end

   // Distinct overflow rates, so a wrong baud source shows as bit length
   always @(posedge clk) begin
      ovf_tog <= ~ovf_tog;
      timer1_ovf <= ~ovf_tog;
      timer2_ovf <= 1'b1;
   end

   // Shared data pin: the port wins while its enable is low
   assign rx_line = rxd_oe_n ? node_out : rxd_out;

   esp_node i_node (.clk(clk), .line_in(txd), .line_out(node_out));

   esp_uart i_dut (
      .clk(clk), .nrst(nrst), .mode_select_high(mode_select_high),
      .mode_select_low(mode_select_low),
      .multiproc_select_bit(multiproc_select_bit),
      .baud_doubler(baud_doubler), .rx_enable(rx_enable),
      .baud_src_timer2(baud_src_timer2), .timer2_ext_clk(timer2_ext_clk),
      .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
      .serial_buffer_wr(serial_buffer_wr),
      .serial_buffer_wdata(serial_buffer_wdata),
      .tx_ninth_bit(tx_ninth_bit), .tx_done_clr(tx_done_clr),
      .rx_done_clr(rx_done_clr), .slave_addr(slave_addr),
      .slave_mask(slave_mask), .rxd_in(rx_line), .rxd_out(rxd_out),
      .rxd_oe_n(rxd_oe_n), .txd(txd), .tx_done_flag(tx_done_flag),
      .rx_done_flag(rx_done_flag), .rx_ninth_bit(rx_ninth_bit),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word)
   );

   task automatic wrap_up();
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic setup(input logic [1:0] m, input logic db, input logic t2,
         input logic ext, input logic en, input logic mp);
      @(posedge clk);
      {mode_select_high, mode_select_low} <= m;
      baud_doubler <= db;
      baud_src_timer2 <= t2;
      timer2_ext_clk <= ext;
      rx_enable <= en;
      multiproc_select_bit <= mp;
   endtask : setup

   task automatic write_tx(input logic [7:0] d, input logic nb);
      @(posedge clk);
      serial_buffer_wr <= 1'b1;
      serial_buffer_wdata <= d;
      tx_ninth_bit <= nb;
      @(posedge clk);
      serial_buffer_wr <= 1'b0;
   endtask : write_tx

   task automatic clr_flags();
      @(posedge clk);
      tx_done_clr <= 1'b1;
      rx_done_clr <= 1'b1;
      @(posedge clk);
      tx_done_clr <= 1'b0;
      rx_done_clr <= 1'b0;
   endtask : clr_flags

   // Shift clock period seen on txd after a write
   task automatic m0(input logic mp, input int per);
      int w;
      int c;
      w = 0;
      c = 0;
      setup(esp_pkg::MODE_SHIFT, 1'b0, 1'b0, 1'b0, 1'b0, mp);
      write_tx(8'h5A, 1'b0);
      while (txd !== 1'b0 && w < 500) begin
         @(posedge clk);
         w++;
      end
      check("shift_oe_n", {15'h0, rxd_oe_n}, 16'h0000);
      check("shift_data", {15'h0, rxd_out}, 16'h0000);
      while (txd === 1'b0 && c < 50) begin
         @(posedge clk);
         c++;
      end
      while (txd === 1'b1 && c < 50) begin
         @(posedge clk);
         c++;
      end
      check("shift_period", c[15:0], per[15:0]);
      repeat (150) @(posedge clk);
      clr_flags();
   endtask : m0

   // Bit period is checked as the start bit length, so data bit 0 is 1
   task automatic tx_case(input logic [1:0] m, input logic db,
         input logic t2, input logic ext, input int per,
         input logic [7:0] d, input logic nb);
      logic [10:0] got;
      logic [10:0] exp;
      int low;
      int n;
      n = (m == esp_pkg::MODE_VAR8) ? 10 : 11;
      exp = (n == 10) ? {2'b01, d, 1'b0} : {1'b1, nb, d, 1'b0};
      setup(m, db, t2, ext, 1'b0, 1'b0);
      fork
         i_node.capture(n, per, got, low);
         begin
            write_tx(d, nb);
            @(negedge clk);
            check("tx_flag_early", {15'h0, tx_done_flag}, 16'h0);
         end
      join
      check("tx_frame", {5'h0, got}, {5'h0, exp});
      check("tx_bit_len", low[15:0], per[15:0]);
      check("tx_flag", {15'h0, tx_done_flag}, 16'h0001);
      repeat (per) @(posedge clk);
      clr_flags();
   endtask : tx_case

   task automatic rx_frame(input int n, input logic [7:0] d,
         input logic nb, input logic sb, input int gb);
      logic [10:0] f;
      f = (n == 10) ? {1'b0, sb, d, 1'b0} : {sb, nb, d, 1'b0};
      i_node.send(f, n, 32, gb);
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask : rx_frame

   task automatic drain(input logic [8:0] exp);
      check("rx_valid", {15'h0, rx_valid}, 16'h0001);
      check("rx_word", {7'h0, rx_word}, {7'h0, exp});
      @(posedge clk);
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : drain

   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      wrap_up();
   end

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check("idle", {13'h0, txd, rxd_oe_n, rxd_out}, 16'h0007);
      check("flags", {13'h0, tx_done_flag, rx_done_flag, rx_valid},
            16'h0);
      m0(1'b0, 12);
      m0(1'b1, 4);
      tx_case(esp_pkg::MODE_FIX9, 0, 0, 0, 64, 8'hA5, 1'b1);
      tx_case(esp_pkg::MODE_FIX9, 1, 0, 0, 32, 8'h3B, 1'b0);
      tx_case(esp_pkg::MODE_VAR8, 0, 0, 0, 64, 8'hC7, 1'b0);
      tx_case(esp_pkg::MODE_VAR8, 1, 0, 0, 32, 8'h81, 1'b0);
      tx_case(esp_pkg::MODE_VAR9, 0, 1, 0, 32, 8'h6D, 1'b1);
      tx_case(esp_pkg::MODE_VAR9, 0, 1, 1, 16, 8'hF3, 1'b0);
      // Receive at 32 clocks a bit; buffer stays stalled until drained
      setup(esp_pkg::MODE_VAR8, 1, 0, 0, 0, 0);
      rx_frame(10, 8'h11, 1'b0, 1'b1, -1);
      check("rx_off", {15'h0, rx_done_flag}, 16'h0);
      setup(esp_pkg::MODE_VAR8, 1, 0, 0, 1, 0);
      i_node.send(11'h000, 1, 4, -1);
      repeat (40) @(posedge clk);
      rx_frame(10, 8'h3C, 1'b0, 1'b1, 3);
      check("rx_flag", {15'h0, rx_done_flag}, 16'h0001);
      check("rx_stop", {15'h0, rx_ninth_bit}, 16'h0001);
      rx_frame(10, 8'h77, 1'b0, 1'b1, -1);
      check("rx_hold", {7'h0, rx_word}, 16'h013C);
      clr_flags();
      setup(esp_pkg::MODE_VAR8, 1, 0, 0, 1, 1);
      rx_frame(10, 8'h55, 1'b0, 1'b0, -1);
      check("mp_stop", {15'h0, rx_done_flag}, 16'h0);
      setup(esp_pkg::MODE_VAR9, 1, 1, 0, 1, 0);
      rx_frame(11, 8'h96, 1'b0, 1'b1, -1);
      check("rx9", {14'h0, rx_done_flag, rx_ninth_bit}, 16'h0002);
      clr_flags();
      rx_frame(11, 8'hE1, 1'b1, 1'b1, -1);
      check("rx_full", {15'h0, rx_done_flag}, 16'h0);
      drain(9'h13C);
      drain(9'h096);
      check("rx_empty", {15'h0, rx_valid}, 16'h0);
      setup(esp_pkg::MODE_VAR9, 1, 1, 0, 1, 1);
      rx_frame(11, 8'h5B, 1'b1, 1'b1, -1);
      rx_frame(11, 8'h5A, 1'b0, 1'b1, -1);
      check("addr_gate", {15'h0, rx_done_flag}, 16'h0);
      rx_frame(11, 8'h5A, 1'b1, 1'b1, -1);
      check("addr_hit", {14'h0, rx_done_flag, rx_ninth_bit}, 16'h0003);
      drain(9'h15A);
      // Shift receive: five low bits, then three high ones
      clr_flags();
      setup(esp_pkg::MODE_SHIFT, 0, 0, 0, 1, 1);
      i_node.send(11'h000, 1, 20, -1);
      repeat (20) @(posedge clk);
      @(negedge clk);
      check("m0_rx", {15'h0, rx_done_flag}, 16'h0001);
      drain(9'h1E0);
      wrap_up();
   end
endmodule : esp_uart_bench
